// *** pkg/sa_params.svh ***
`ifndef SA_PARAMS_SVH
`define SA_PARAMS_SVH
// Blink half period in ms and derived cycle count at 20 MHz
`define SA_CLK_HZ        20000000
`define SA_BLINK_HALF_MS 250
`define SA_BLINK_CYC     ((`SA_CLK_HZ / 1000) * `SA_BLINK_HALF_MS)
// Plasma threshold: current above max / 1024
`define SA_PLASMA_SHIFT  10
`define SA_CUR_W         16
// Indicator count per panel type
`define SA_LEDS_STD      10
`define SA_LEDS_MINI     9
// Reset value of active-low lines (inactive high)
`define SA_LINE_IDLE     1'b1
`endif

// *** pkg/sa_pkg.sv ***
package sa_pkg;
  // Selected target-life counter
  typedef enum logic [1:0] {
    SA_TGT_NONE,
    SA_TGT_1,
    SA_TGT_2,
    SA_TGT_3
  } sa_target_t;

  // Conditions reported by the controller
  typedef struct packed {
    logic output_on;
    logic contactor_closed;
    logic at_setpoint;
    logic overcurrent;
    logic life_ended;
    logic ramping;
    logic ramp_paused;
    logic temp_high;
    logic water_fault;
    logic vac_fault;
    logic aux_fault;
  } sa_cond_t;

  // Status indicator LEDs (standard panel order)
  typedef struct packed {
    logic arc;
    logic ramp;
    logic setpoint;
    logic plasma;
    logic output_led;
    logic target_life;
    logic temp;
    logic water;
    logic vacuum;
    logic auxiliary;
  } sa_leds_t;
endpackage : sa_pkg

// *** hdl/sa_annunciator.sv ***
// Behaviour
// - Close one of three relay pairs showing the selected counter; none when no target is selected.
// - Drive two select lines that together encode the selected target.
// - Output line low while contactor closed and output turned on.
// - Setpoint line low while output equals requested setpoint.
// - Arc line low when current reaches the overcurrent trip point.
// - Life-end line low once selected counter's target life ran out.
// - Arc event lights arc LED, fires shutdown circuit, sounds alarm.
// - Ramp LED steady while ramping, flashing when paused, off otherwise and always off at setpoint.
// - Setpoint LED steady at setpoint, flashing plus alarm off setpoint.
// - Setpoint LED lights or flashes only while plasma LED is lit.
// - Plasma LED when output on and current above max over 1024.
// - Output LED lights whenever output is turned on.
// - Ten indicators on standard panel, nine on reduced without auxiliary.
// - Overbar status lines are active low, asserted by driving low.
`timescale 1ns/1ps
`include "sa_params.svh"

module sa_annunciator
  import sa_pkg::*;
#(
  parameter int BLINK_CYC = `SA_BLINK_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire sa_cond_t             cond_in,
  input  wire sa_target_t           target_sel,
  input  wire logic [`SA_CUR_W-1:0] current_meas,
  input  wire logic [`SA_CUR_W-1:0] current_max,
  input  wire logic                 mini_panel,
  output logic                      output_on_n,
  output logic                      at_setpoint_n,
  output logic                      arc_detect_n,
  output logic                      target_life_end_n,
  output logic                      target_select_lines,
  output logic                      target_select_lines_b,
  output logic [2:0]                relay_close,
  output logic                      arc_shutdown_circuit,
  output logic                      alarm,
  output sa_leds_t                  leds
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Flashing LED is lit only in the bright half of the common blink
  function automatic logic sa_flash(input logic lit, input logic phase);
    return lit & phase;
  endfunction : sa_flash

  // Counter number to contact pair; only one pair is ever closed,
  // and counter zero leaves every pair open
  function automatic logic [2:0] sa_relay_dec(input logic [1:0] sel);
    logic [2:0] pair;
    pair = 3'h0;
    unique case (sa_target_t'(sel))
      SA_TGT_1:    pair = 3'h1;
      SA_TGT_2:    pair = 3'h2;
      SA_TGT_3:    pair = 3'h4;
      SA_TGT_NONE: pair = 3'h0;
    endcase
    return pair;
  endfunction : sa_relay_dec

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Conditions come from pins or other logic of unknown timing
  sa_cond_t             c_meta_q, c_meta_d, c_q, c_d;
  logic [1:0]           t_meta_q, t_meta_d, t_q, t_d;
  logic                 m_meta_q, m_meta_d, m_q, m_d;

  always_comb begin
    c_meta_d = cond_in;
    c_d      = c_meta_q;
    t_meta_d = target_sel;
    t_d      = t_meta_q;
    m_meta_d = mini_panel;
    m_d      = m_meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      c_meta_q <= '0;
      c_q      <= '0;
      t_meta_q <= 2'h0;
      t_q      <= 2'h0;
      m_meta_q <= 1'b0;
      m_q      <= 1'b0;
    end else begin
      c_meta_q <= c_meta_d;
      c_q      <= c_d;
      t_meta_q <= t_meta_d;
      t_q      <= t_d;
      m_meta_q <= m_meta_d;
      m_q      <= m_d;
    end
  end

  // ---------------------------------------------------------------
  // Common blink generator
  // ---------------------------------------------------------------
  // One counter for all LEDs so flashing ones stay in phase
  logic [31:0] blink_cnt_q, blink_cnt_d;
  logic        blink_q, blink_d;

  always_comb begin
    // Wraps once per half period, so one full blink is two wraps
    blink_cnt_d = blink_cnt_q + 32'h1;
    blink_d     = blink_q;
    if (blink_cnt_q >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_d = 32'h0;
      blink_d     = ~blink_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
    end
  end

  // ---------------------------------------------------------------
  // Status lines, relays and indicators
  // ---------------------------------------------------------------
  // Threshold is a shift; current is sampled unsynchronised as a
  // slowly moving converter word from the same clock domain.
  logic     plasma;
  logic     on_n_d, sp_n_d, arc_n_d, life_n_d, sel_a_d, sel_b_d;
  logic     on_n_q, sp_n_q, arc_n_q, life_n_q, sel_a_q, sel_b_q;
  logic [2:0] relay_d, relay_q;
  logic     shut_d, shut_q, alarm_d, alarm_q;
  sa_leds_t leds_d, leds_q;

  assign plasma = c_q.output_on &&
                  (current_meas > (current_max >> `SA_PLASMA_SHIFT));

  always_comb begin
    // Active-low lines: low means asserted
    on_n_d   = ~(c_q.contactor_closed & c_q.output_on);
    sp_n_d   = ~c_q.at_setpoint;
    arc_n_d  = ~c_q.overcurrent;
    life_n_d = ~(c_q.life_ended && (t_q != 2'h0));
    // Two lines encode the selected target
    sel_a_d  = t_q[0];
    sel_b_d  = t_q[1];
    relay_d  = sa_relay_dec(t_q);
    shut_d   = c_q.overcurrent;

    leds_d            = '0;
    leds_d.arc        = c_q.overcurrent;
    leds_d.ramp       = c_q.ramping ||
                        sa_flash(c_q.ramp_paused, blink_q);
    // Ramp is over at setpoint even if the ramp flag lags behind
    if (c_q.at_setpoint) begin
      leds_d.ramp     = 1'b0;
    end
    leds_d.plasma     = plasma;
    // Setpoint LED gated by plasma
    if (plasma) begin
      leds_d.setpoint = c_q.at_setpoint ? 1'b1 : blink_q;
    end
    leds_d.output_led = c_q.output_on;
    // Fault LEDs flash in the shared phase so they never beat
    leds_d.target_life = sa_flash(c_q.life_ended, blink_q);
    leds_d.temp       = sa_flash(c_q.temp_high, blink_q);
    leds_d.water      = sa_flash(c_q.water_fault, blink_q);
    leds_d.vacuum     = sa_flash(c_q.vac_fault, blink_q);
    // Reduced panel has no auxiliary LED; the fault then shows nowhere, not even in the alarm
    leds_d.auxiliary  = !m_q && sa_flash(c_q.aux_fault, blink_q);

    // Alarm covers arc, setpoint lost under plasma and a spent target
    alarm_d = c_q.overcurrent
           || (plasma && !c_q.at_setpoint)
           || c_q.life_ended;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      // Remote side sees nothing asserted until real conditions arrive
      on_n_q   <= `SA_LINE_IDLE;
      sp_n_q   <= `SA_LINE_IDLE;
      arc_n_q  <= `SA_LINE_IDLE;
      life_n_q <= `SA_LINE_IDLE;
      sel_a_q  <= 1'b0;
      sel_b_q  <= 1'b0;
      relay_q  <= 3'h0;
      shut_q   <= 1'b0;
      alarm_q  <= 1'b0;
      leds_q   <= '0;
    end else begin
      on_n_q   <= on_n_d;
      sp_n_q   <= sp_n_d;
      arc_n_q  <= arc_n_d;
      life_n_q <= life_n_d;
      sel_a_q  <= sel_a_d;
      sel_b_q  <= sel_b_d;
      relay_q  <= relay_d;
      shut_q   <= shut_d;
      alarm_q  <= alarm_d;
      leds_q   <= leds_d;
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  // Every pin comes straight from a flop, so no glitch reaches a cable
  assign output_on_n           = on_n_q;
  assign at_setpoint_n         = sp_n_q;
  assign arc_detect_n          = arc_n_q;
  assign target_life_end_n     = life_n_q;
  assign target_select_lines   = sel_a_q;
  assign target_select_lines_b = sel_b_q;
  assign relay_close           = relay_q;
  assign arc_shutdown_circuit  = shut_q;
  assign alarm                 = alarm_q;
  assign leds                  = leds_q;

endmodule : sa_annunciator

// *** bench/sa_remote_mon.sv ***
`timescale 1ns/1ps
// -------------------------------------------------
// Remote controller view of the user port lines
// -------------------------------------------------
module sa_remote_mon (
  input  wire logic       output_on_n,
  input  wire logic       at_setpoint_n,
  input  wire logic       arc_detect_n,
  input  wire logic       target_life_end_n,
  output logic      [3:0] seen
);
  // Low means true on every status line, so invert at the pins
  assign seen = ~{output_on_n, at_setpoint_n, arc_detect_n,
                  target_life_end_n};
endmodule : sa_remote_mon

// *** bench/sa_annunciator_assertions.sv ***
`timescale 1ns/1ps
// -------------------------------------------------
// Port checker
// -------------------------------------------------
module sa_annunciator_assertions
  import sa_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire sa_cond_t   cond_in,
  input wire logic       mini_panel,
  input wire logic       output_on_n,
  input wire logic       at_setpoint_n,
  input wire logic       arc_detect_n,
  input wire logic       target_life_end_n,
  input wire logic       target_select_lines,
  input wire logic       target_select_lines_b,
  input wire logic [2:0] relay_close,
  input wire logic       arc_shutdown_circuit,
  input wire logic       alarm,
  input wire sa_leds_t   leds
);
  logic [1:0] rc_q;
  logic       ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Edges since reset; synchroniser history is valid only at 3
  always_ff @(posedge clk) begin
    if (!rstn) rc_q <= 2'h0;
    else if (rc_q != 2'h3) rc_q <= rc_q + 2'h1;
  end
  assign ok = (rc_q == 2'h3);
  sequence s_arc_act;
    leds.arc && arc_shutdown_circuit && alarm;
  endsequence
  a_output_line_low: assert property (ok |-> output_on_n == !($past(
    cond_in.output_on, 3) && $past(cond_in.contactor_closed, 3)))
    else $error("output line mismatch");
  a_setpoint_line: assert property (ok |->
    at_setpoint_n == !$past(cond_in.at_setpoint, 3))
    else $error("setpoint line mismatch");
  a_arc_line: assert property (ok |->
    arc_detect_n == !$past(cond_in.overcurrent, 3))
    else $error("arc line mismatch");
  a_arc_actions: assert property (!arc_detect_n |-> s_arc_act)
    else $error("arc actions missing");
  a_relay_one_hot: assert property (relay_close ==
    {target_select_lines_b & target_select_lines,
     target_select_lines_b & !target_select_lines,
     !target_select_lines_b & target_select_lines})
    else $error("relay pattern mismatch");
  a_life_needs_sel: assert property (!target_life_end_n |->
    (target_select_lines || target_select_lines_b))
    else $error("life end without target");
  a_setpoint_plasma: assert property (leds.setpoint |-> leds.plasma)
    else $error("setpoint led without plasma");
  a_output_led: assert property (ok |->
    leds.output_led == $past(cond_in.output_on, 3))
    else $error("output led mismatch");
  a_idle_after_rst: assert property ($rose(rstn) |-> output_on_n &&
    at_setpoint_n && arc_detect_n && target_life_end_n)
    else $error("lines not idle after reset");
  a_plasma_needs_on: assert property (leds.plasma |-> leds.output_led)
    else $error("plasma led without output");
  a_alarm_off_sp: assert property ((leds.plasma && at_setpoint_n) |-> alarm)
    else $error("no alarm off setpoint");
  a_ramp_off_sp: assert property (!at_setpoint_n |-> !leds.ramp)
    else $error("ramp led lit at setpoint");
  a_aux_off_mini: assert property (ok |->
    !(leds.auxiliary && $past(mini_panel, 3)))
    else $error("aux led on reduced panel");
endmodule : sa_annunciator_assertions
bind sa_annunciator sa_annunciator_assertions u_chk (
  .clk                   (clk),
  .rstn                  (rstn),
  .cond_in               (cond_in),
  .mini_panel            (mini_panel),
  .output_on_n           (output_on_n),
  .at_setpoint_n         (at_setpoint_n),
  .arc_detect_n          (arc_detect_n),
  .target_life_end_n     (target_life_end_n),
  .target_select_lines   (target_select_lines),
  .target_select_lines_b (target_select_lines_b),
  .relay_close           (relay_close),
  .arc_shutdown_circuit  (arc_shutdown_circuit),
  .alarm                 (alarm),
  .leds                  (leds)
);

// *** bench/sa_annunciator_tb_top.sv ***
`timescale 1ns/1ps
module sa_annunciator_tb_top
  import sa_pkg::*;
;
  logic clk = 0, rstn = 0, mp = 0, prev = 0;
  sa_cond_t cond = '0;
  sa_target_t tsel = SA_TGT_NONE;
  logic [15:0] cm = 16'h0, cx = 16'h0;
  logic on_n, sp_n, arc_n, le_n, sl, slb, shut, alm;
  logic [2:0] rel;
  logic [3:0] seen;
  sa_leds_t leds;
  int err_total = 0, checks = 0, cyc = 0, chg;
  // -------------------------------------------------
  // Clock, design and remote monitor
  // -------------------------------------------------
  always #25 clk = ~clk;
  sa_annunciator #(.BLINK_CYC(4)) dut (.clk(clk), .rstn(rstn),
    .cond_in(cond), .target_sel(tsel), .current_meas(cm),
    .current_max(cx), .mini_panel(mp), .output_on_n(on_n),
    .at_setpoint_n(sp_n), .arc_detect_n(arc_n), .target_life_end_n(le_n),
    .target_select_lines(sl), .target_select_lines_b(slb),
    .relay_close(rel), .arc_shutdown_circuit(shut), .alarm(alm),
    .leds(leds));
  sa_remote_mon u_mon (.output_on_n(on_n), .at_setpoint_n(sp_n),
    .arc_detect_n(arc_n), .target_life_end_n(le_n), .seen(seen));
  task check(input logic [15:0] s, e, input string what);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Steady outputs only; flashing bits depend on blink phase
  function logic [15:0] exp_f(input sa_cond_t c, input sa_target_t t,
                              input logic [15:0] m, x);
    logic pl;
    pl = c.output_on && (m > (x >> 10));
    return {2'h0, c.output_on & c.contactor_closed, c.at_setpoint,
      c.overcurrent, c.life_ended && t != SA_TGT_NONE, t[1], t[0],
      t == SA_TGT_3, t == SA_TGT_2, t == SA_TGT_1, c.overcurrent,
      c.overcurrent | (pl & !c.at_setpoint) | c.life_ended, c.overcurrent,
      c.output_on, pl};
  endfunction : exp_f
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    void'($urandom(86));
    repeat (2) @(negedge clk);
    rstn = 1;
    @(negedge clk) check({12'h0, seen}, 16'h0, "idle lines");
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      cond = sa_cond_t'(11'($urandom));
      tsel = sa_target_t'($urandom_range(0, 3));
      if (i == 0) tsel = SA_TGT_NONE;
      cm = 16'($urandom_range(0, 127));
      cx = 16'($urandom);
      mp = 1'($urandom_range(0, 1));
      repeat (5) @(negedge clk);
      check({2'h0, seen, slb, sl, rel, shut, alm, leds.arc,
        leds.output_led, leds.plasma}, exp_f(cond, tsel, cm, cx),
        "steady outputs");
      check(16'(leds.auxiliary & mp), 16'h0, "aux on mini");
    end
    $display("test random done");
    cond = '0;
    cond.output_on = 1;
    cond.ramp_paused = 1;
    cond.life_ended = 1;
    cond.temp_high = 1;
    cond.water_fault = 1;
    cond.vac_fault = 1;
    cond.aux_fault = 1;
    mp = 0;
    cm = 16'h0064;
    cx = 16'h0400;
    repeat (5) @(negedge clk);
    chg = 0;
    prev = leds.ramp;
    for (int i = 0; i < 24; i++) begin
      @(negedge clk) check(16'(leds.setpoint), 16'(leds.ramp),
        "phase");
      check(16'({leds.target_life, leds.temp, leds.water, leds.vacuum,
        leds.auxiliary}), 16'({5{leds.ramp}}), "fault flash");
      if (leds.ramp !== prev) chg++;
      prev = leds.ramp;
    end
    check(16'(chg >= 5), 16'h1, "ramp blink");
    check(16'(alm), 16'h1, "alarm off setpoint");
    cond.ramping = 1;
    cond.ramp_paused = 0;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 8; i++)
      @(negedge clk) check(16'(leds.ramp), 16'h1, "ramp steady");
    cond.at_setpoint = 1;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 8; i++)
      @(negedge clk) check(16'({leds.ramp, leds.setpoint}), 16'h1,
        "at setpoint");
    $display("test blink done");
    stop_test;
  end
endmodule : sa_annunciator_tb_top
